// *** design/ucgp_cfg.svh ***
// constants for the uart channel pin port: offsets, fields, resets
`ifndef UCGP_CFG_SVH
`define UCGP_CFG_SVH
`define UCGP_PIN_CONFIG_IDX 8'h18
`define UCGP_PIN_DATA_IDX 8'h19
`define UCGP_PIN_CONFIG_ADDR 12'h060
`define UCGP_PIN_DATA_ADDR 12'h064
`define UCGP_DIR_LSB 0
`define UCGP_DRV_LSB 4
`define UCGP_OUT_LSB 0
`define UCGP_IN_LSB 4
`define UCGP_PIN_CONFIG_RST 8'h00
`define UCGP_PIN_DATA_RST 4'h0
`define UCGP_SYNC_STAGES 2
`endif

// *** design/ucgp_pkg.sv ***
// types shared by the uart channel pin port
`default_nettype none
package ucgp_pkg;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } ucgp_pin_drv_t;
  typedef struct packed {
    logic [3:0] drive_type_sel;
    logic [3:0] direction;
  } ucgp_cfg_t;
  typedef enum logic [1:0] {
    UCGP_IDLE,
    UCGP_ACCESS
  } ucgp_apb_st_t;
endpackage
`default_nettype wire

// *** design/ucgp_pin_drv.sv ***
// one pin's driver: direction, drive type and output level to pad enables
`default_nettype none
module ucgp_pin_drv (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_direction,
  input wire logic i_drive_type_sel,
  input wire logic i_output_level,
  output logic o_pin_o,
  output logic o_pin_oe
);
  logic o_ff;
  logic oe_ff;
  logic nxt_o;
  logic nxt_oe;

  always_comb begin
    nxt_o = 1'b0;
    nxt_oe = 1'b0;
    if (i_direction) begin
      if (i_drive_type_sel) begin
        // open drain: drive low only, release for high
        nxt_o = 1'b0;
        nxt_oe = ~i_output_level;
      end else begin
        nxt_o = i_output_level;
        nxt_oe = 1'b1;
      end
    end
    // input: released, weak pulldown sits in the pad
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (i_ce) begin
      o_ff <= nxt_o;
      oe_ff <= nxt_oe;
    end
  end

  assign o_pin_o = o_ff;
  assign o_pin_oe = oe_ff;

  od_low_only_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_direction && i_drive_type_sel) |=> (o_pin_o == 1'b0))
    else $error("open drain pin drove high");
  input_released_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_direction) |=> !o_pin_oe)
    else $error("input pin was driven");
endmodule // ucgp_pin_drv
`default_nettype wire

// *** design/ucgp_port.sv ***
// apb register file and pin logic of one uart channel's four pins
//
// Added by the designer: the APB interface to the registers.
`default_nettype none
`include "ucgp_cfg.svh"
module ucgp_port
  import ucgp_pkg::*;
#(
  parameter int unsigned CHANNEL = 0,
  parameter int unsigned NUM_PINS = 4,
  parameter int unsigned ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [3:0] i_pin_i,
  output logic [3:0] o_pin_o,
  output logic [3:0] o_pin_oe,
  output logic [5:0] o_first_pin
);
  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (NUM_PINS != 4) begin : g_bad_pins
    $error("ucgp_port serves exactly four pins");
  end
  if (CHANNEL > 3) begin : g_bad_chan
    $error("ucgp_port channel must be 0 to 3");
  end
  if (ADDR_W < 8) begin : g_bad_aw
    $error("ucgp_port address too narrow");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ucgp_cfg_t cfg_ff;
  logic [3:0] out_level_ff;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [5:0] first_pin_ff;
  ucgp_apb_st_t st_ff;
  ucgp_pin_drv_t drv;
  logic hit_cfg;
  logic hit_data;
  logic setup;
  logic [31:0] nxt_prdata;
  logic nxt_slverr;

  localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'(`UCGP_PIN_CONFIG_ADDR);
  localparam logic [ADDR_W-1:0] A_DAT = ADDR_W'(`UCGP_PIN_DATA_ADDR);

  assign hit_cfg = (i_paddr == A_CFG);
  assign hit_data = (i_paddr == A_DAT);
  assign setup = i_psel && !i_penable;

  // ---------------------------------------------------------------
  // apb slave: one wait-free access, answer in the access cycle
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= UCGP_IDLE;
    end else if (i_ce) begin
      case (st_ff)
        UCGP_IDLE: begin
          if (setup) begin
            st_ff <= UCGP_ACCESS;
          end
        end
        UCGP_ACCESS: begin
          st_ff <= setup ? UCGP_ACCESS : UCGP_IDLE;
        end
        default: begin
          st_ff <= UCGP_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    if (hit_cfg) begin
      nxt_prdata[7:0] = cfg_ff;
    end else if (hit_data) begin
      nxt_prdata[`UCGP_IN_LSB +: 4] = sync2_ff;
      nxt_prdata[`UCGP_OUT_LSB +: 4] = out_level_ff;
    end else begin
      nxt_slverr = 1'b1;
    end
  end

  // ready is raised one cycle after setup so the access phase ends there
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (i_ce) begin
      pready_ff <= setup;
      pslverr_ff <= setup && nxt_slverr;
      if (setup && !i_pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers: writes take effect at the edge that completes access
  // ---------------------------------------------------------------
  logic wr_now;
  // the state machine must agree that this is the access cycle
  assign wr_now = i_psel && i_penable && pready_ff && i_pwrite &&
    i_pstrb[0] && (st_ff == UCGP_ACCESS);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= `UCGP_PIN_CONFIG_RST;
    end else if (i_ce && wr_now && hit_cfg) begin
      cfg_ff.drive_type_sel <= i_pwdata[`UCGP_DRV_LSB +: 4];
      cfg_ff.direction <= i_pwdata[`UCGP_DIR_LSB +: 4];
    end
  end

  // level is stored regardless of direction and applies when output
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_level_ff <= `UCGP_PIN_DATA_RST;
    end else if (i_ce && wr_now && hit_data) begin
      out_level_ff <= i_pwdata[`UCGP_OUT_LSB +: 4];
    end
  end

  // ---------------------------------------------------------------
  // pin input synchroniser; readback lags pins by two cycles
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else if (i_ce) begin
      sync1_ff <= i_pin_i;
      sync2_ff <= sync1_ff;
    end
  end

  // global index of local pin 0, a fixed mapping per channel
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      first_pin_ff <= 6'h00;
    end else if (i_ce) begin
      first_pin_ff <= 6'(CHANNEL * NUM_PINS);
    end
  end

  // ---------------------------------------------------------------
  // pin drivers; i_clk is the reference clock, a stopped clock
  // freezes the pads in their last state
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_pin
    ucgp_pin_drv u_drv (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_direction(cfg_ff.direction[g]),
      .i_drive_type_sel(cfg_ff.drive_type_sel[g]),
      .i_output_level(out_level_ff[g]),
      .o_pin_o(drv.o[g]),
      .o_pin_oe(drv.oe[g])
    );
  end

  assign o_pin_o = drv.o;
  assign o_pin_oe = drv.oe;
  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_first_pin = first_pin_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  push_pull_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cfg_ff.direction[0] && !cfg_ff.drive_type_sel[0]) |=>
    (o_pin_oe[0] && o_pin_o[0] == $past(out_level_ff[0])))
    else $error("push-pull pin 0 level wrong");
  od_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cfg_ff.direction[1] && cfg_ff.drive_type_sel[1] &&
     out_level_ff[1]) |=> !o_pin_oe[1])
    else $error("open drain high not released");
  input_hiz_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !cfg_ff.direction[2]) |=> !o_pin_oe[2])
    else $error("input pin 2 driven");
  cfg_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_now && hit_cfg) |=>
    (cfg_ff == $past(i_pwdata[7:0])))
    else $error("config write lost");
  dir_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_now && hit_cfg && i_pwdata[3]) |=> ##1 o_pin_oe[3] ||
    cfg_ff.drive_type_sel[3])
    else $error("direction bit 3 ignored");
  level_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_now && hit_data) |=>
    (out_level_ff == $past(i_pwdata[3:0])))
    else $error("output level write lost");
  level_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!(wr_now && hit_data)) |=> $stable(out_level_ff))
    else $error("output level changed without write");
  readback_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && setup && !i_pwrite && hit_data) |=>
    (o_prdata[7:4] == $past(sync2_ff)))
    else $error("input level readback wrong");
  reset_zero_a: assert property (@(posedge i_clk)
    i_rst |=> (cfg_ff == 8'h00 && out_level_ff == 4'h0) || !i_rst)
    else $error("registers not zero after reset");
  map_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce |=> o_first_pin == 6'(CHANNEL * 4))
    else $error("channel pin map wrong");

  cov_od_c: cover property (@(posedge i_clk)
    cfg_ff.direction[0] && cfg_ff.drive_type_sel[0]);
  cov_pp_c: cover property (@(posedge i_clk)
    cfg_ff.direction[0] && !cfg_ff.drive_type_sel[0] && o_pin_o[0]);
  cov_err_c: cover property (@(posedge i_clk) o_pready && o_pslverr);
  cov_late_c: cover property (@(posedge i_clk)
    wr_now && hit_data && !cfg_ff.direction[0]);
endmodule // ucgp_port
`default_nettype wire

// *** dv/ucgp_pin_model.sv ***
// external circuitry on the four pads of one channel
`default_nettype none
module ucgp_pin_model (
  input wire logic [3:0] i_pin_o,
  input wire logic [3:0] i_pin_oe,
  input wire logic [3:0] i_ext_en,
  input wire logic [3:0] i_ext_val,
  output logic [3:0] o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pad falls to the weak pulldown unless something outside
  // drives it, such as the pull-up an open-drain line needs
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (i_pin_oe[k]) begin
        o_pad[k] = i_pin_o[k];
      end else if (i_ext_en[k]) begin
        o_pad[k] = i_ext_val[k];
      end else begin
        o_pad[k] = 1'b0;
      end
    end
  end
endmodule // ucgp_pin_model
`default_nettype wire

// *** dv/ucgp_port_bench.sv ***
// self-checking bench of one uart channel's pin port
`default_nettype none
`include "ucgp_cfg.svh"
module ucgp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, psel, pen, pwr, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, ext_en, ext_val, pad, pin_o, pin_oe;
  logic [5:0] first_pin;
  logic [32:0] q[$];
  logic [32:0] e;
  int failures, checks;
  // -----------------------------------------------------------------
  // design and far side
  // -----------------------------------------------------------------
  ucgp_port #(.CHANNEL(2)) dut (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pin_i(pad),
    .o_pin_o(pin_o), .o_pin_oe(pin_oe), .o_first_pin(first_pin));
  ucgp_pin_model far (.i_pin_o(pin_o), .i_pin_oe(pin_oe),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // -----------------------------------------------------------------
  // checking
  // -----------------------------------------------------------------
  task automatic chk_rd(input string nm, input logic [32:0] x,
                        input logic [32:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [7:0] x,
                         input logic [7:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // o is only meaningful where the pad is driven, so it is masked by oe
  function automatic logic [7:0] drv_exp(input logic [7:0] c,
                                         input logic [3:0] l);
    logic [3:0] o, oe;
    for (int k = 0; k < 4; k++) begin
      oe[k] = c[k] & (~c[k+4] | ~l[k]);
      o[k] = c[k] & ~c[k+4] & l[k];
    end
    return {o, oe};
  endfunction
  // each answered transfer takes the oldest note; writes only show pslverr
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      e = q.pop_front();
      if (pwr) begin
        chk_rd("wr_err", {e[32], 32'h0}, {pslverr, 32'h0});
      end else begin
        chk_rd("rd", e, {pslverr, prdata});
      end
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [32:0] x);
    int n;
    q.push_back(x);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    logic [7:0] c;
    logic [31:0] d;
    logic [7:0] x;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    ext_en = 4'h0;
    ext_val = 4'h0;
    failures = 0;
    checks = 0;
    void'($urandom(54));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_pin("first_pin", 8'h08, {2'h0, first_pin});
    chk_pin("pins", 8'h00, {pin_o & pin_oe, pin_oe});
    apb(1'b0, `UCGP_PIN_CONFIG_ADDR, 32'h0, 4'h0, 33'h0);
    apb(1'b0, `UCGP_PIN_DATA_ADDR, 32'h0, 4'h0, 33'h0);
    apb(1'b1, `UCGP_PIN_DATA_ADDR, 32'h0a, 4'hf, 33'h0);
    repeat (2) @(posedge clk);
    chk_pin("pins", 8'h00, {pin_o & pin_oe, pin_oe});
    apb(1'b1, `UCGP_PIN_CONFIG_ADDR, 32'h0f, 4'hf, 33'h0);
    repeat (2) @(posedge clk);
    chk_pin("pins", 8'haf, {pin_o & pin_oe, pin_oe});
    apb(1'b1, `UCGP_PIN_CONFIG_ADDR, 32'h0, 4'he, 33'h0);
    apb(1'b1, 12'h068, 32'h0, 4'hf, {1'b1, 32'h0});
    apb(1'b0, 12'h070, 32'h0, 4'h0, {1'b1, 32'h0});
    apb(1'b0, `UCGP_PIN_CONFIG_ADDR, 32'h0, 4'h0, 33'h0f);
    for (int i = 0; i < 24; i++) begin
      c = 8'($urandom);
      d = $urandom;
      ext_val <= 4'($urandom);
      ext_en <= (i == 0) ? 4'h0 : 4'hf;
      apb(1'b1, `UCGP_PIN_CONFIG_ADDR, {24'h0, c}, 4'hf, 33'h0);
      apb(1'b1, `UCGP_PIN_DATA_ADDR, d, 4'hf, 33'h0);
      repeat (5) @(posedge clk);
      x = drv_exp(c, d[3:0]);
      chk_pin("pins", x, {pin_o & pin_oe, pin_oe});
      x[7:4] = (x[3:0] & x[7:4]) | (~x[3:0] & ext_en & ext_val);
      apb(1'b0, `UCGP_PIN_CONFIG_ADDR, 32'h0, 4'h0, {25'h0, c});
      apb(1'b0, `UCGP_PIN_DATA_ADDR, 32'h0, 4'h0,
          {25'h0, x[7:4], d[3:0]});
    end
    test_done;
  end
  initial begin
    #100us;
    failures++;
    test_done;
  end
endmodule // ucgp_port_bench
`default_nettype wire
